// ---- verilog/apot_pkg.sv ----
// Function
// - 8-bit straight binary, 7.8125mV step
// - transitions halfway between steps, first at half
// - below negative full scale: flag, all zeros
// - above positive full scale: flag, all ones
// - flag low inside full-scale range
// - offset trim: code flickers 7f and 80
// - full-scale trim: code flickers fe and ff
// - host clock phases at least 25ns
// - track while high, sample on falling edge
// - result at fifth falling edge after sample
// - new conversion on every falling edge
// - host keeps conversion clock above 10kHz; host holds it high while its buffer is full
// - discard 20 clocks after power-up or stop
// - power-down low switches amplifiers off
// - outputs stay driven during power-down
// - after power-down exit discard 20 clocks
`default_nettype none
package apot_pkg;
    // sample word: flag above an 8-bit code
    localparam int CODE_W = 8;
    localparam int WORD_W = 9;
    localparam int FLAG_POS = 8;
    // falling edges from sample to result
    localparam int LATENCY = 5;
    // analog input in units of 1/32 mV, signed
    localparam int INPUT_W = 17;
    localparam int LSB_UNITS = 250;
    localparam int HALF_LSB_UNITS = 125;
    localparam int FS_UNITS = 32000;
    // codes of note
    localparam logic [7:0] CODE_MIN = 8'h00;
    localparam logic [7:0] CODE_MAX = 8'hff;
    localparam logic [7:0] CODE_MID_LOW = 8'h7f;
    localparam logic [7:0] CODE_MID_HIGH = 8'h80;
    localparam logic [7:0] CODE_TOP_LOW = 8'hfe;
    // system clock
    localparam int CLK_PERIOD_PS = 4000;
    // shortest clock phase
    localparam int MIN_PHASE_NS = 25;
    localparam int MIN_PHASE_CYCLES =
        (MIN_PHASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // slowest conversion clock, 10kHz: 100us period
    localparam int MAX_PERIOD_NS = 100000;
    localparam int MAX_HALF_CYCLES =
        (MAX_PERIOD_NS * 1000 / 2) / CLK_PERIOD_PS;
    // clock stop that loses dynamic state
    localparam int CLOCK_STOP_US = 100;
    localparam int STOP_CYCLES =
        (CLOCK_STOP_US * 1000000) / CLK_PERIOD_PS;
    // clocks to run before data is trusted
    localparam int WARMUP_CLOCKS = 20;
    // host capture delay after its falling edge
    localparam int CAPTURE_DELAY = 2;
    // host output buffer
    localparam int FIFO_DEPTH = 8;
    // device warm-up state
    typedef enum logic [2:0] {
        APOT_DEV_COLD  = 3'b001,
        APOT_DEV_READY = 3'b010,
        APOT_DEV_OFF   = 3'b100
    } apot_dev_state_t;
endpackage
`default_nettype wire

// ---- verilog/apot_link_if.sv ----
`default_nettype none
// pins between the converter and the host logic
interface apot_link_if;
    logic       conv_clk;            // conversion clock from host
    logic       power_down_bar;      // low powers the converter down
    logic [7:0] sample_code;         // result code
    logic       range_exceeded_flag; // out-of-range marker
    modport device (
        input  conv_clk,
        input  power_down_bar,
        output sample_code,
        output range_exceeded_flag
    );
    modport host (
        output conv_clk,
        output power_down_bar,
        input  sample_code,
        input  range_exceeded_flag
    );
endinterface
`default_nettype wire

// ---- verilog/apot_device.sv ----
`default_nettype none
// converter end: samples analog_in on conv_clk falls and
// delivers each result five falls later
module apot_device #(
    parameter int STOP_CYCLES = apot_pkg::STOP_CYCLES,
    parameter int LATENCY     = apot_pkg::LATENCY
) (
    input  wire logic                                clock,
    input  wire logic                                reset_n,
    input  wire logic signed [apot_pkg::INPUT_W-1:0] analog_in,
    apot_link_if.device                              link,
    output logic                                     bias_on,
    output logic                                     settled
);
    localparam int IDLE_W = $clog2(STOP_CYCLES + 1);
    localparam int WARM_W = $clog2(apot_pkg::WARMUP_CLOCKS + 1);
    localparam int WW     = apot_pkg::WORD_W;

    // refuse settings the pipeline cannot hold
    if (LATENCY < 1) begin : g_bad_latency
        $error("apot_device: LATENCY must be at least 1");
    end
    if (STOP_CYCLES < 2) begin : g_bad_stop
        $error("apot_device: STOP_CYCLES must be at least 2");
    end

    // ideal transfer: returns {flag, code}
    function automatic logic [WW-1:0] apot_convert(
        input logic signed [apot_pkg::INPUT_W-1:0] v
    );
        int                         sv;
        int                         sh;
        int                         q;
        logic                       f;
        logic [apot_pkg::CODE_W-1:0] c;
        sv = int'(v);
        // offset by half a step so edges fall midway
        sh = sv + apot_pkg::FS_UNITS + apot_pkg::HALF_LSB_UNITS;
        q  = sh / apot_pkg::LSB_UNITS;
        f  = 1'b0;
        c  = apot_pkg::CODE_MIN;
        if (sv > apot_pkg::FS_UNITS) begin
            // over range pins to all ones
            f = 1'b1;
            c = apot_pkg::CODE_MAX;
        end else if (sv < -apot_pkg::FS_UNITS) begin
            // under range pins to all zeros
            f = 1'b1;
            c = apot_pkg::CODE_MIN;
        end else if (q > int'(apot_pkg::CODE_MAX)) begin
            // last half step below full scale saturates
            c = apot_pkg::CODE_MAX;
        end else begin
            c = q[apot_pkg::CODE_W-1:0];
        end
        // flag and code leave together in one word
        return {f, c};
    endfunction

    // edge detect and tracking state
    logic                                conv_prev;      // last clk level
    logic                                next_conv_prev;
    logic signed [apot_pkg::INPUT_W-1:0] track;          // tracked input
    logic signed [apot_pkg::INPUT_W-1:0] next_track;
    logic                                fall;           // conv_clk fell

    // pipeline state
    logic [WW-1:0] stage      [LATENCY];  // conversions in flight
    logic [WW-1:0] next_stage [LATENCY];
    logic [WW-1:0] out_word;              // word on the pins
    logic [WW-1:0] next_out_word;
    logic          advance;               // pipeline steps this cycle

    // warm-up state
    apot_pkg::apot_dev_state_t state;
    apot_pkg::apot_dev_state_t next_state;
    logic [IDLE_W-1:0]         idle;      // cycles since last fall
    logic [IDLE_W-1:0]         next_idle;
    logic                      stopped;   // clock stood too long
    logic [WARM_W-1:0]         warm;      // falls seen while cold
    logic [WARM_W-1:0]         next_warm;
    logic                      next_bias_on;
    logic                      next_settled;

    // track while high, freeze on the fall
    always_comb begin
        next_conv_prev = link.conv_clk;
        fall           = conv_prev & ~link.conv_clk;
        // the value held is the last one seen high
        next_track = link.conv_clk ? analog_in : track;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            conv_prev <= 1'b0;
            track     <= '0;
        end else begin
            conv_prev <= next_conv_prev;
            track     <= next_track;
        end
    end

    // pipeline: one new sample per fall, one result out
    always_comb begin
        // amplifiers are off while power-down is low
        advance = fall & link.power_down_bar & bias_on;
        for (int i = 0; i < LATENCY; i++) begin
            next_stage[i] = stage[i];
        end
        next_out_word = out_word;
        if (advance) begin
            // every fall launches a fresh conversion
            next_stage[0] = apot_convert(track);
            for (int i = 1; i < LATENCY; i++) begin
                next_stage[i] = stage[i-1];
            end
            // fifth fall after capture reaches the pins
            next_out_word = stage[LATENCY-1];
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            for (int i = 0; i < LATENCY; i++) begin
                stage[i] <= '0;
            end
            out_word <= '0;
        end else begin
            for (int i = 0; i < LATENCY; i++) begin
                stage[i] <= next_stage[i];
            end
            // held until the next fall
            out_word <= next_out_word;
        end
    end

    // pins are always driven, even while powered down
    assign link.sample_code =
        out_word[apot_pkg::CODE_W-1:0];
    assign link.range_exceeded_flag =
        out_word[apot_pkg::FLAG_POS];

    // warm-up tracking: dynamic nodes need clocks after any upset
    always_comb begin
        stopped = (idle == IDLE_W'(STOP_CYCLES));
        // idle count saturates so a long stop stays seen
        if (fall) begin
            next_idle = '0;
        end else if (stopped) begin
            next_idle = idle;
        end else begin
            next_idle = idle + IDLE_W'(1);
        end
        next_state = state;
        case (state)
            apot_pkg::APOT_DEV_COLD: begin
                if (!link.power_down_bar) begin
                    next_state = apot_pkg::APOT_DEV_OFF;
                end else if (fall && warm ==
                        WARM_W'(apot_pkg::WARMUP_CLOCKS - 1)) begin
                    next_state = apot_pkg::APOT_DEV_READY;
                end
            end
            apot_pkg::APOT_DEV_READY: begin
                if (!link.power_down_bar) begin
                    next_state = apot_pkg::APOT_DEV_OFF;
                end else if (stopped) begin
                    // a clock stop drops the dynamic state
                    next_state = apot_pkg::APOT_DEV_COLD;
                end
            end
            apot_pkg::APOT_DEV_OFF: begin
                // waking needs a fresh warm-up
                if (link.power_down_bar) begin
                    next_state = apot_pkg::APOT_DEV_COLD;
                end
            end
            default: begin
                next_state = apot_pkg::APOT_DEV_COLD;
            end
        endcase
        // warm count only runs while cold and clocked
        if (state != apot_pkg::APOT_DEV_COLD || stopped) begin
            next_warm = '0;
        end else if (fall) begin
            next_warm = warm + WARM_W'(1);
        end else begin
            next_warm = warm;
        end
        next_bias_on = (next_state != apot_pkg::APOT_DEV_OFF);
        next_settled = (next_state == apot_pkg::APOT_DEV_READY);
    end

    // power-up counts as cold
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state   <= apot_pkg::APOT_DEV_COLD;
            idle    <= '0;
            warm    <= '0;
            bias_on <= 1'b1;
            settled <= 1'b0;
        end else begin
            state   <= next_state;
            idle    <= next_idle;
            warm    <= next_warm;
            bias_on <= next_bias_on;
            settled <= next_settled;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/apot_host.sv ----
`default_nettype none
// sample buffer between capture and the user
module apot_fifo #(
    parameter int WIDTH = apot_pkg::WORD_W,
    parameter int DEPTH = apot_pkg::FIFO_DEPTH
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // pointers wrap by overflow, so depth must be a power of two
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("apot_fifo: DEPTH must be a power of two >= 2");
    end
    logic [WIDTH-1:0] mem [DEPTH]; // storage
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;       // words held
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    logic             next_in_ready;
    logic             next_out_valid;

    // full and empty are registered from the next count, so both
    // flags leave the buffer straight from flip-flops
    assign out_data  = mem[rd_ptr];

    always_comb begin
        push        = in_valid & in_ready;
        pop         = out_valid & out_ready;
        next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
        case ({push, pop})
            2'b10:   next_count = count + (AW+1)'(1);
            2'b01:   next_count = count - (AW+1)'(1);
            default: next_count = count;
        endcase
        next_in_ready  = (next_count != (AW+1)'(DEPTH));
        next_out_valid = (next_count != '0);
    end

    // storage has no reset; empty words are never shown
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            in_ready  <= next_in_ready;
            out_valid <= next_out_valid;
        end
    end
endmodule

// host end: makes conv_clk, steers power-down, drops
// warm-up results and buffers the rest
module apot_host #(
    parameter int HALF_CYCLES = apot_pkg::MIN_PHASE_CYCLES,
    parameter int STOP_CYCLES = apot_pkg::STOP_CYCLES
) (
    input  wire logic                         clock,
    input  wire logic                         reset_n,
    input  wire logic                         run,
    input  wire logic                         sleep,
    apot_link_if.host                         link,
    output logic                              out_valid,
    input  wire logic                         out_ready,
    output logic      [apot_pkg::WORD_W-1:0]  out_data,
    output logic                              cal_mid_hit,
    output logic                              cal_top_hit
);
    localparam int PH_W   = $clog2(HALF_CYCLES + 1);
    localparam int IDLE_W = $clog2(STOP_CYCLES + 1);
    localparam int WARM_W = $clog2(apot_pkg::WARMUP_CLOCKS + 1);
    localparam int CD     = apot_pkg::CAPTURE_DELAY;

    // phase bounds keep 25ns phases and above 10kHz
    if (HALF_CYCLES < apot_pkg::MIN_PHASE_CYCLES) begin : g_fast
        $error("apot_host: HALF_CYCLES below shortest phase");
    end
    if (HALF_CYCLES > apot_pkg::MAX_HALF_CYCLES) begin : g_slow
        $error("apot_host: HALF_CYCLES below 10kHz rate");
    end
    if (STOP_CYCLES < 2) begin : g_bad_stop
        $error("apot_host: STOP_CYCLES must be at least 2");
    end

    logic [PH_W-1:0]   phase;       // cycles in current phase
    logic [PH_W-1:0]   next_phase;
    logic              conv_clk;    // driven level
    logic              next_conv_clk;
    logic              pdb;         // power_down_bar level
    logic              next_pdb;
    logic [CD-1:0]     cap_pipe;    // delay from fall to capture
    logic [CD-1:0]     next_cap_pipe;
    logic [IDLE_W-1:0] idle;        // cycles since our last fall
    logic [IDLE_W-1:0] next_idle;
    logic [WARM_W-1:0] discard;     // results dropped so far
    logic [WARM_W-1:0] next_discard;
    logic              next_cal_mid;
    logic              next_cal_top;
    logic              phase_done;
    logic              toggle;
    logic              fall_now;
    logic              capture;
    logic              stopped;
    logic              warm_ok;
    logic              push;
    logic              fifo_ready;
    logic [apot_pkg::WORD_W-1:0] word;

    assign link.conv_clk       = conv_clk;
    assign link.power_down_bar = pdb;

    // clock divider; a fall waits for buffer room, so a full
    // buffer stretches the high phase instead of dropping
    always_comb begin
        phase_done = (phase == PH_W'(HALF_CYCLES - 1));
        toggle     = run & phase_done & (~conv_clk | fifo_ready);
        fall_now   = toggle & conv_clk;
        if (!run || toggle) begin
            next_phase = '0;
        end else if (phase_done) begin
            next_phase = phase;
        end else begin
            next_phase = phase + PH_W'(1);
        end
        next_conv_clk = toggle ? ~conv_clk : conv_clk;
        next_cap_pipe = {cap_pipe[CD-2:0], fall_now};
        next_pdb      = ~sleep;
    end

    // capture and warm-up discard
    always_comb begin
        capture = cap_pipe[CD-1];
        // code and flag are taken in the same cycle
        word = {link.range_exceeded_flag, link.sample_code};
        // a stall past the limit costs a fresh warm-up
        stopped = (idle == IDLE_W'(STOP_CYCLES));
        if (fall_now) begin
            next_idle = '0;
        end else if (stopped) begin
            next_idle = idle;
        end else begin
            next_idle = idle + IDLE_W'(1);
        end
        warm_ok = (discard == WARM_W'(apot_pkg::WARMUP_CLOCKS));
        if (!pdb || stopped) begin
            next_discard = '0;
        end else if (capture && !warm_ok) begin
            next_discard = discard + WARM_W'(1);
        end else begin
            next_discard = discard;
        end
        push = capture & warm_ok & pdb & fifo_ready;
        next_cal_mid = cal_mid_hit;
        next_cal_top = cal_top_hit;
        if (push) begin
            // offset trim target: flicker across mid-scale
            next_cal_mid = (word == {1'b0, apot_pkg::CODE_MID_LOW}) ||
                           (word == {1'b0, apot_pkg::CODE_MID_HIGH});
            // gain trim target: flicker at the top two codes
            next_cal_top = (word == {1'b0, apot_pkg::CODE_TOP_LOW}) ||
                           (word == {1'b0, apot_pkg::CODE_MAX});
        end
    end

    // start low and powered down until the user says otherwise
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            phase       <= '0;
            conv_clk    <= 1'b0;
            pdb         <= 1'b0;
            cap_pipe    <= '0;
            idle        <= '0;
            discard     <= '0;
            cal_mid_hit <= 1'b0;
            cal_top_hit <= 1'b0;
        end else begin
            phase       <= next_phase;
            conv_clk    <= next_conv_clk;
            pdb         <= next_pdb;
            cap_pipe    <= next_cap_pipe;
            idle        <= next_idle;
            discard     <= next_discard;
            cal_mid_hit <= next_cal_mid;
            cal_top_hit <= next_cal_top;
        end
    end

    apot_fifo #(
        .WIDTH (apot_pkg::WORD_W),
        .DEPTH (apot_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .reset_n   (reset_n),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (word),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );
endmodule
`default_nettype wire

// ---- verif/apot_link_monitor.sv ----
`default_nettype none
// watches the pins between converter and host
module apot_link_monitor (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       conv_clk,
    input wire logic       power_down_bar,
    input wire logic [7:0] sample_code,
    input wire logic       range_exceeded_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    // one domain, so clock and reset are shared
    default clocking mon_cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    // word as the host captures it
    wire logic [8:0] word = {range_exceeded_flag, sample_code};
    high_phase_a: assert property (
        $rose(conv_clk) |-> conv_clk [*7])
        else $error("conv clock high phase too short");
    low_phase_a: assert property (
        $fell(conv_clk) |-> !conv_clk [*7])
        else $error("conv clock low phase too short");
    // pins move only on the edge after a seen fall
    code_update_a: assert property (
        $changed(sample_code) |-> !$past(conv_clk) && $past(conv_clk, 2))
        else $error("code changed away from a fall");
    flag_update_a: assert property (
        $changed(range_exceeded_flag)
        |-> !$past(conv_clk) && $past(conv_clk, 2))
        else $error("flag changed away from a fall");
    flag_code_a: assert property (
        range_exceeded_flag |-> sample_code == 8'h00 || sample_code == 8'hff)
        else $error("flag high with an inner code");
    // three lows give the device time to see the sleep level
    sleep_freeze_a: assert property (
        (!power_down_bar) [*3] |-> $stable(word))
        else $error("pins moved while powered down");
    hold_word_a: assert property (
        $changed(word) |=> $stable(word) [*8])
        else $error("result did not hold until next fall");
    track_hold_a: assert property (
        conv_clk |-> $stable(word))
        else $error("result changed while tracking");
    fall_c: cover property ($fell(conv_clk));
    under_c: cover property (range_exceeded_flag && sample_code == 8'h00);
    over_c: cover property (range_exceeded_flag && sample_code == 8'hff);
    sleep_c: cover property ($fell(power_down_bar));
endmodule
`default_nettype wire

// ---- verif/pipelined_adc_output_timing_test.sv ----
`default_nettype none
// host and converter joined by the link, checked end to end
module pipelined_adc_output_timing_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CORNERS [10] = '{-32001, 32001, -32000, 32000, -31875,
                                    -31876, -126, -125, 31624, 31625};
    logic              clock;     // system clock
    logic              reset_n;   // synchronous reset
    logic              run;       // host makes conv_clk
    logic              sleep;     // host powers down
    logic              out_ready; // user pops
    logic              out_valid; // word waiting
    logic [8:0]        out_data;  // flag over code
    logic signed [16:0] analog_in; // input, 1/32 mV
    logic              bias_on;   // amplifiers on
    logic              settled;   // warm-up done
    logic              cal_mid;   // host saw a mid-scale word
    logic              cal_top;   // host saw a top word
    logic              draining;  // buffer may hold several words
    logic              prev_clk;  // conv_clk at last edge
    logic [8:0]        pipe [5];  // model stages
    logic [8:0]        link_q [$]; // words seen on the pins
    int depth, nfall, corner, i;   // model fill, falls, corner index
    int miscompares, compares;
    apot_link_if link ();
    apot_device #(.STOP_CYCLES(64)) u_apot_device (.clock(clock),
        .reset_n(reset_n), .analog_in(analog_in), .link(link),
        .bias_on(bias_on), .settled(settled));
    apot_host #(.STOP_CYCLES(64)) u_apot_host (.clock(clock),
        .reset_n(reset_n), .run(run), .sleep(sleep), .link(link),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .cal_mid_hit(cal_mid), .cal_top_hit(cal_top));
    apot_link_monitor u_apot_link_monitor (.clock(clock), .reset_n(reset_n),
        .conv_clk(link.conv_clk), .power_down_bar(link.power_down_bar),
        .sample_code(link.sample_code),
        .range_exceeded_flag(link.range_exceeded_flag));
    // ideal transfer: half-step offsets, clipped at full scale
    function automatic logic [8:0] expect_word(input int v);
        int c;
        if (v > apot_pkg::FS_UNITS) return 9'h1ff;
        if (v < -apot_pkg::FS_UNITS) return 9'h100;
        c = (v + apot_pkg::FS_UNITS + apot_pkg::HALF_LSB_UNITS)
            / apot_pkg::LSB_UNITS;
        return (c > 255) ? 9'h0ff : 9'(c);
    endfunction
    task automatic check(input string what, input logic [8:0] exp,
                         input logic [8:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // let n edges pass, then step just past the last one
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // bounded wait for the first buffered word
    task automatic wait_valid();
        int n;
        n = 0;
        while (out_valid !== 1'b1 && n < 2000) begin
            @(posedge clock);
            #1;
            n++;
        end
        check("out_valid", 9'h1, 9'(out_valid));
        if (n >= 2000) stop_test();
    endtask
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // pipeline model, pop checker and input driver on every edge;
    // a fall counts only where the device would take it
    always @(posedge clock) begin
        logic fall;
        fall = reset_n && prev_clk && !link.conv_clk
               && link.power_down_bar && bias_on;
        if (!reset_n) depth = 0;
        if (reset_n && out_valid === 1'b1 && out_ready) begin
            // popped words must come in the order seen on the pins
            while (link_q.size() > 0 && link_q[0] !== out_data)
                void'(link_q.pop_front());
            check("fifo word", 9'(link_q.size() > 0), 9'h1);
            if (link_q.size() > 0) void'(link_q.pop_front());
            // with one word in flight the trim flags tell of this word
            if (!draining) begin
                check("cal mid",
                      9'(out_data == 9'h07f || out_data == 9'h080),
                      9'(cal_mid));
                check("cal top",
                      9'(out_data == 9'h0fe || out_data == 9'h0ff),
                      9'(cal_top));
            end
        end
        prev_clk = link.conv_clk;
        #1;
        if (fall) begin
            nfall++;
            if (depth >= apot_pkg::LATENCY)
                check("link word", pipe[4],
                      {link.range_exceeded_flag, link.sample_code});
            link_q.push_back({link.range_exceeded_flag, link.sample_code});
            for (int k = 4; k > 0; k--) pipe[k] = pipe[k-1];
            pipe[0] = expect_word(analog_in);
            depth++;
            // every fourth sample a corner, so corners also reach the
            // buffer after warm-up; held through the next high
            if (corner % 4 == 0) begin
                analog_in = 17'(CORNERS[(corner / 4) % 10]);
            end else begin
                analog_in = 17'(int'($urandom_range(68000)) - 34000);
            end
            corner++;
        end
    end
    initial begin
        reset_n = 1'b0;
        run = 1'b0;
        sleep = 1'b0;
        out_ready = 1'b0;
        analog_in = 17'h00000;
        prev_clk = 1'b0;
        draining = 1'b0;
        {depth, nfall, corner, miscompares, compares} = '0;
        void'($urandom(32'h8916c27a));
        repeat (20) @(posedge clock);
        #1;
        reset_n = 1'b1;
        run = 1'b1;
        out_ready = 1'b1;
        nfall = 0;
        wait_valid();
        check("warm falls", 9'(nfall >= 20), 9'h1);
        check("settled", 9'(settled), 9'h1);
        tick(1400);
        // fill the buffer until the host stalls, then drain it
        out_ready = 1'b0;
        draining = 1'b1;
        tick(400);
        check("full valid", 9'(out_valid), 9'h1);
        run = 1'b0;
        out_ready = 1'b1;
        i = 0;
        while (out_valid === 1'b1 && i < 20) begin
            @(posedge clock);
            #1;
            i++;
        end
        check("fifo depth", 9'(i), 9'(apot_pkg::FIFO_DEPTH));
        draining = 1'b0;
        run = 1'b1;
        tick(200);
        sleep = 1'b1;
        tick(100);
        check("bias asleep", 9'(bias_on), 9'h0);
        sleep = 1'b0;
        nfall = 0;
        wait_valid();
        check("wake falls", 9'(nfall >= 20), 9'h1);
        stop_test();
    end
endmodule
`default_nettype wire
